// [lmr_consts.vh]
`ifndef LMR_CONSTS_VH
`define LMR_CONSTS_VH
`define LMR_ADDR_LAT     6'h02
`define LMR_ADDR_IO      6'h03
`define LMR_ADDR_TEMP    6'h04
`define LMR_ADDR_ID      6'h05
`define LMR_ADDR_CTRL    6'h0D
`define LMR_LAT_RESET    8'h00
`define LMR_IO_RESET     8'h31
`define LMR_TEMP_RESET   8'h03
`define LMR_RATE_DEFAULT 3'h3
`define LMR_RATE_DERATE  3'h6
`define LMR_LAT_WLEV_BIT 7
`define LMR_IO_PROT_BIT  2
`define LMR_TEMP_WR_MASK 8'h78
`define LMR_TEMP_PRE_BIT 4
`define LMR_BL32_EXTRA   8'h08
`define LMR_ID_DEFAULT   8'h3C
`endif

// [lmr_latency_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "lmr_consts.vh"
module lmr_latency_decode (
	input  wire [7:0] lat_cfg_i,
	input  wire       rd_inv_i,
	output reg  [7:0] read_latency_o,
	output reg  [7:0] write_latency_o,
	output reg  [7:0] rtp_count_o
);
	// --------------------------------
	// Table lookups
	// --------------------------------
	always @*
	begin
		case (lat_cfg_i[2:0])
		3'h0: read_latency_o = rd_inv_i ? 8'h06 : 8'h06;
		3'h1: read_latency_o = rd_inv_i ? 8'h0C : 8'h0A;
		3'h2: read_latency_o = rd_inv_i ? 8'h10 : 8'h0E;
		3'h3: read_latency_o = rd_inv_i ? 8'h16 : 8'h14;
		3'h4: read_latency_o = rd_inv_i ? 8'h1C : 8'h18;
		3'h5: read_latency_o = rd_inv_i ? 8'h20 : 8'h1C;
		3'h6: read_latency_o = rd_inv_i ? 8'h24 : 8'h20;
		default: read_latency_o = rd_inv_i ? 8'h28 : 8'h24;
		endcase
		case (lat_cfg_i[2:0])
		3'h4: rtp_count_o = 8'h0A;
		3'h5: rtp_count_o = 8'h0C;
		3'h6: rtp_count_o = 8'h0E;
		3'h7: rtp_count_o = 8'h10;
		default: rtp_count_o = 8'h08;
		endcase
		case (lat_cfg_i[5:3])
		3'h0: write_latency_o = 8'h04;
		3'h1: write_latency_o = lat_cfg_i[6] ? 8'h08 : 8'h06;
		3'h2: write_latency_o = lat_cfg_i[6] ? 8'h0C : 8'h08;
		3'h3: write_latency_o = lat_cfg_i[6] ? 8'h12 : 8'h0A;
		3'h4: write_latency_o = lat_cfg_i[6] ? 8'h16 : 8'h0C;
		3'h5: write_latency_o = lat_cfg_i[6] ? 8'h1A : 8'h0E;
		3'h6: write_latency_o = lat_cfg_i[6] ? 8'h1E : 8'h10;
		default: write_latency_o = lat_cfg_i[6] ? 8'h22 : 8'h12;
		endcase
	end
endmodule // lmr_latency_decode
`default_nettype wire

// [lmr_precharge_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "lmr_consts.vh"
module lmr_precharge_timer (
	input  wire       ref_clk_i,
	input  wire       rst_b_i,
	input  wire       start_i,
	input  wire       bl32_i,
	input  wire [7:0] rtp_count_i,
	output reg        precharge_o,
	output reg        busy_o
);
	reg [7:0] cnt_q;
	// --------------------------------
	// Countdown to internal precharge
	// --------------------------------
	always @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_q       <= 8'h00;
			precharge_o <= 1'b0;
			busy_o      <= 1'b0;
		end
		else
		begin
			precharge_o <= 1'b0;
			if (start_i)
			begin
				// Extra clocks cover the second half of a long burst
				cnt_q  <= bl32_i ? rtp_count_i + `LMR_BL32_EXTRA
				                 : rtp_count_i;
				busy_o <= 1'b1;
			end
			else if (busy_o)
			begin
				if (cnt_q <= 8'h01)
				begin
					busy_o      <= 1'b0;
					precharge_o <= 1'b1;
				end
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule // lmr_precharge_timer
`default_nettype wire

// [lmr_mode_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "lmr_consts.vh"
module lmr_mode_regs #(
	parameter [7:0] MAKER_ID = `LMR_ID_DEFAULT // Arbitrary value
) (
	input  wire       ref_clk_i,
	input  wire       rst_b_i,
	input  wire       mrw_i,
	input  wire       mrr_i,
	input  wire [5:0] ma_i,
	input  wire [7:0] op_i,
	input  wire       init_done_i,
	input  wire [2:0] sensor_rate_i,
	input  wire       derate_i,
	input  wire       rd_ap_i,
	input  wire       bl32_i,
	output reg  [7:0] rd_data_o,
	output reg        rd_valid_o,
	output reg  [7:0] read_latency_o,
	output reg  [7:0] write_latency_o,
	output reg  [7:0] rtp_count_o,
	output reg        write_leveling_o,
	output reg        read_inversion_enable_o,
	output reg        write_inversion_enable_o,
	output reg        pullup_calibration_point_o,
	output reg        write_postamble_length_o,
	output reg  [2:0] pulldown_drive_strength_o,
	output reg        repair_protection_o,
	output reg        repair_entry_o,
	output reg        self_refresh_cancel_o,
	output reg  [1:0] thermal_offset_o,
	output reg        precharge_o
);
	// --------------------------------
	// Storage
	// --------------------------------
	reg  [7:0] lat_q [0:1];
	reg  [7:0] io_q  [0:1];
	reg  [7:0] temp_q;
	reg        prot_q;
	reg  [7:0] ctrl_q;
	reg  [2:0] rs1_q;
	reg  [2:0] rs2_q;
	reg        dr1_q;
	reg        dr2_q;
	reg        id1_q;
	reg        id2_q;
	reg        ap1_q;
	reg        ap2_q;
	reg        b1_q;
	reg        b2_q;
	wire       wsel;
	wire       osel;
	wire [2:0] rate_now;
	wire [7:0] rl_w;
	wire [7:0] wl_w;
	wire [7:0] rtp_w;
	wire       pc_w;
	reg        ap_d1_q;
	assign wsel = ctrl_q[6];
	assign osel = ctrl_q[7];
	// Sensor level is known only once initialization finishes
	assign rate_now = !id2_q ? `LMR_RATE_DEFAULT :
	                  dr2_q  ? `LMR_RATE_DERATE : rs2_q;

	// --------------------------------
	// Input synchronisers
	// --------------------------------
	always @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rs1_q <= 3'h0;
			rs2_q <= 3'h0;
			dr1_q <= 1'b0;
			dr2_q <= 1'b0;
			id1_q <= 1'b0;
			id2_q <= 1'b0;
			ap1_q <= 1'b0;
			ap2_q <= 1'b0;
			b1_q  <= 1'b0;
			b2_q  <= 1'b0;
			ap_d1_q <= 1'b0;
		end
		else
		begin
			// Multi-bit sensor code may tear briefly; temp_q[2:0] takes the torn value and the next cycle corrects it
			rs1_q <= sensor_rate_i;
			rs2_q <= rs1_q;
			dr1_q <= derate_i;
			dr2_q <= dr1_q;
			id1_q <= init_done_i;
			id2_q <= id1_q;
			ap1_q <= rd_ap_i;
			ap2_q <= ap1_q;
			b1_q  <= bl32_i;
			b2_q  <= b1_q;
			ap_d1_q <= ap2_q;
		end
	end

	// --------------------------------
	// Mode register writes
	// --------------------------------
	always @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lat_q[0] <= `LMR_LAT_RESET;
			lat_q[1] <= `LMR_LAT_RESET;
			io_q[0]  <= `LMR_IO_RESET;
			io_q[1]  <= `LMR_IO_RESET;
			temp_q   <= `LMR_TEMP_RESET;
			prot_q   <= 1'b0;
			ctrl_q   <= 8'h00;
		end
		else
		begin
			// While leveling, only a latency write is acted on
			if (mrw_i && (!lat_q[osel][`LMR_LAT_WLEV_BIT] ||
			    ma_i == `LMR_ADDR_LAT))
			begin
				case (ma_i)
				`LMR_ADDR_LAT: lat_q[wsel] <= op_i;
				`LMR_ADDR_IO:
				begin
					io_q[wsel] <= op_i;
					if (op_i[`LMR_IO_PROT_BIT])
						prot_q <= 1'b1;
				end
				`LMR_ADDR_TEMP:
				begin
					temp_q[6:5] <= op_i[6:5];
					temp_q[3]   <= op_i[3];
					if (!(prot_q && op_i[`LMR_TEMP_PRE_BIT]))
						temp_q[4] <= op_i[4];
				end
				`LMR_ADDR_CTRL: ctrl_q <= op_i;
				default: ;
				endcase
			end
			temp_q[2:0] <= rate_now;
			// A change wins over a same-cycle read clear
			if (id2_q && rate_now != temp_q[2:0])
				temp_q[7] <= 1'b1;
			else if (mrr_i && ma_i == `LMR_ADDR_TEMP)
				temp_q[7] <= 1'b0;
		end
	end

	// --------------------------------
	// Mode register reads
	// --------------------------------
	always @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rd_data_o  <= 8'h00;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= mrr_i;
			if (mrr_i)
			begin
				case (ma_i)
				`LMR_ADDR_LAT:  rd_data_o <= lat_q[wsel];
				`LMR_ADDR_IO:   rd_data_o <= {io_q[wsel][7:3], prot_q,
				                              io_q[wsel][1:0]};
				`LMR_ADDR_TEMP: rd_data_o <= temp_q;
				`LMR_ADDR_ID:   rd_data_o <= MAKER_ID;
				`LMR_ADDR_CTRL: rd_data_o <= ctrl_q;
				default:        rd_data_o <= 8'h00;
				endcase
			end
		end
	end

	// --------------------------------
	// Active set point decode
	// --------------------------------
	lmr_latency_decode u_dec (
		.lat_cfg_i       (lat_q[osel]),
		.rd_inv_i        (io_q[osel][6]),
		.read_latency_o  (rl_w),
		.write_latency_o (wl_w),
		.rtp_count_o     (rtp_w)
	);

	lmr_precharge_timer u_pc (
		.ref_clk_i   (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.start_i     (ap2_q && !ap_d1_q),
		.bl32_i      (b2_q),
		.rtp_count_i (rtp_w),
		.precharge_o (pc_w),
		.busy_o      ()
	);

	always @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			read_latency_o             <= 8'h06;
			write_latency_o            <= 8'h04;
			rtp_count_o                <= 8'h08;
			write_leveling_o           <= 1'b0;
			read_inversion_enable_o    <= 1'b0;
			write_inversion_enable_o   <= 1'b0;
			pullup_calibration_point_o <= 1'b1;
			write_postamble_length_o   <= 1'b0;
			pulldown_drive_strength_o  <= 3'h6;
			repair_protection_o        <= 1'b0;
			repair_entry_o             <= 1'b0;
			self_refresh_cancel_o      <= 1'b0;
			thermal_offset_o           <= 2'h0;
			precharge_o                <= 1'b0;
		end
		else
		begin
			read_latency_o             <= rl_w;
			write_latency_o            <= wl_w;
			rtp_count_o                <= rtp_w;
			write_leveling_o           <= lat_q[osel][7];
			read_inversion_enable_o    <= io_q[osel][6];
			write_inversion_enable_o   <= io_q[osel][7];
			pullup_calibration_point_o <= io_q[osel][0];
			write_postamble_length_o   <= io_q[osel][1];
			pulldown_drive_strength_o  <= io_q[osel][5:3];
			repair_protection_o        <= prot_q;
			repair_entry_o             <= temp_q[4];
			self_refresh_cancel_o      <= temp_q[3];
			thermal_offset_o           <= temp_q[6:5];
			precharge_o                <= pc_w;
		end
	end
endmodule // lmr_mode_regs
`default_nettype wire

// [lmr_mode_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module lmr_mode_regs_props #(
	parameter [7:0] MAKER_ID = 8'h00
) (
	input wire logic       ref_clk_i,
	input wire logic       rst_b_i,
	input wire logic       mrr_i,
	input wire logic [5:0] ma_i,
	input wire logic [7:0] rd_data_o,
	input wire logic       rd_valid_o,
	input wire logic [7:0] read_latency_o,
	input wire logic [7:0] write_latency_o,
	input wire logic [7:0] rtp_count_o,
	input wire logic       repair_protection_o,
	input wire logic       repair_entry_o,
	input wire logic       precharge_o,
	input wire logic [2:0] pulldown_drive_strength_o,
	input wire logic       pullup_calibration_point_o
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_read_answer: assert property (mrr_i |=> rd_valid_o)
		else $error("read not answered");
	a_ident_value: assert property (mrr_i && ma_i == 6'h05
		|=> rd_data_o == MAKER_ID) else $error("bad maker value");
	a_prot_sticky: assert property (repair_protection_o
		|=> repair_protection_o) else $error("protection dropped");
	a_prot_refuse: assert property (
		repair_protection_o && !repair_entry_o |=> !repair_entry_o)
		else $error("repair entered while protected");
	a_pre_pulse: assert property (precharge_o |=> !precharge_o)
		else $error("precharge not a pulse");
	a_rtp_table: assert property (rtp_count_o inside
		{8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10}) else $error("bad rtp");
	a_wl_table: assert property (write_latency_o inside
		{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12,
		8'h16, 8'h1A, 8'h1E, 8'h22}) else $error("bad write latency");
	a_reset_drive: assert property ($rose(rst_b_i) |->
		pulldown_drive_strength_o == 3'h6 && pullup_calibration_point_o)
		else $error("bad drive default");
	c_ident: cover property (mrr_i && ma_i == 6'h05);
	c_pre: cover property (precharge_o);
	c_prot: cover property (repair_protection_o);
endmodule // lmr_mode_regs_props
`default_nettype wire

// [lmr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lmr_host_model (
	input wire logic       ref_clk_i,
	input wire logic       rd_valid_o,
	input wire logic [7:0] rd_data_o,
	output var logic       mrw_o,
	output var logic       mrr_o,
	output var logic [5:0] ma_o,
	output var logic [7:0] op_o
);
	// ----
	// Commands
	// ----
	initial
	begin
		mrw_o = 1'b0;
		mrr_o = 1'b0;
		ma_o = 6'h3F;
		op_o = 8'h00;
	end
	// One command at a time, so nothing slips in while leveling
	task mode_register_write_cmd(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		mrw_o <= 1'b1;
		ma_o <= a;
		op_o <= d;
		@(posedge ref_clk_i);
		mrw_o <= 1'b0;
		ma_o <= ~a;
		op_o <= ~d;
	endtask
	task mode_register_read_cmd(input logic [5:0] a, output logic [7:0] d, output logic v);
		@(posedge ref_clk_i);
		mrr_o <= 1'b1;
		ma_o <= a;
		@(posedge ref_clk_i);
		mrr_o <= 1'b0;
		ma_o <= ~a;
		#1;
		d = rd_data_o;
		v = rd_valid_o;
	endtask
endmodule // lmr_host_model
`default_nettype wire

// [test_lmr_mode_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_lmr_mode_regs;
	localparam [7:0] MAKER_ID = 8'h5A; // Arbitrary value
	localparam [63:0] RLA = 64'h2420_1C18_140E_0A06;
	localparam [63:0] RLB = 64'h2824_201C_1610_0C06;
	localparam [63:0] WLA = 64'h1210_0E0C_0A08_0604;
	localparam [63:0] WLB = 64'h221E_1A16_120C_0804;
	localparam [63:0] RTP = 64'h100E_0C0A_0808_0808;
	logic clk, rst_b, init_done, derate, rd_ap, bl32, v;
	logic [2:0] rate;
	logic [7:0] d;
	wire mode_register_write_cmd, mode_register_read_cmd, rdv, wlev, rinv, winv, pu, wpst, prot, re, src, pc;
	wire [5:0] ma;
	wire [7:0] op, rdd, rl, wl, rtp;
	wire [2:0] pd;
	wire [1:0] toff;
	int n_errors, check_count, i, n16;
	lmr_mode_regs #(.MAKER_ID(MAKER_ID)) lmr_mode_regs_i (
		.ref_clk_i(clk), .rst_b_i(rst_b), .mrw_i(mode_register_write_cmd), .mrr_i(mode_register_read_cmd),
		.ma_i(ma), .op_i(op), .init_done_i(init_done),
		.sensor_rate_i(rate), .derate_i(derate), .rd_ap_i(rd_ap),
		.bl32_i(bl32), .rd_data_o(rdd), .rd_valid_o(rdv),
		.read_latency_o(rl), .write_latency_o(wl), .rtp_count_o(rtp),
		.write_leveling_o(wlev), .read_inversion_enable_o(rinv),
		.write_inversion_enable_o(winv),
		.pullup_calibration_point_o(pu),
		.write_postamble_length_o(wpst),
		.pulldown_drive_strength_o(pd), .repair_protection_o(prot),
		.repair_entry_o(re), .self_refresh_cancel_o(src),
		.thermal_offset_o(toff), .precharge_o(pc));
	lmr_host_model lmr_host_model_i (.ref_clk_i(clk), .rd_valid_o(rdv),
		.rd_data_o(rdd), .mrw_o(mode_register_write_cmd), .mrr_o(mode_register_read_cmd), .ma_o(ma), .op_o(op));
	// ----
	// Helpers
	// ----
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] e);
		lmr_host_model_i.mode_register_write_cmd(a, e);
		repeat (3) @(posedge clk);
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		lmr_host_model_i.mode_register_read_cmd(a, d, v);
		chk(v, 1);
		chk(d, e);
	endtask
	// Cycles from the read with auto precharge to the pulse
	task pc_len(output int n);
		@(posedge clk) rd_ap <= 1'b1;
		n = 0;
		while (pc !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		rd_ap <= 1'b0;
		if (n >= 100)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		{rst_b, init_done, derate, rd_ap, bl32} = 5'h00;
		rate = 3'h3;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(rl, 6);
		chk(wl, 4);
		chk({pd, pu, rinv, winv}, 8'h34);
		rd(6'h04, 8'h03);
		rd(6'h05, MAKER_ID);
		wr(6'h05, ~MAKER_ID);
		rd(6'h05, MAKER_ID);
		rd(6'h07, 8'h00);
		wr(6'h0D, 8'h40);
		wr(6'h02, 8'h07);
		rd(6'h02, 8'h07);
		chk(rl, 6);
		wr(6'h0D, 8'hC0);
		chk(rl, 36);
		wr(6'h0D, 8'h00);
		rd(6'h02, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			if (i == 8)
				wr(6'h03, 8'hF1);
			wr(6'h02, {1'b0, i[3], i[2:0], i[2:0]});
			chk(rl, i < 8 ? RLA[8*i +: 8] : RLB[8*(i-8) +: 8]);
			chk(wl, i < 8 ? WLA[8*i +: 8] : WLB[8*(i-8) +: 8]);
			chk(rtp, RTP[8*i[2:0] +: 8]);
		end
		chk({rinv, winv}, 2'b11);
		wr(6'h03, 8'h3A);
		chk({pd, pu, wpst}, 5'h1D);
		pc_len(n16);
		// Two sync stages, edge detect, countdown, output register
		chk(n16, 8'h14);
		@(posedge clk) bl32 <= 1'b1;
		pc_len(i);
		chk(i - n16, 8);
		wr(6'h02, 8'h80);
		chk(wlev, 1);
		wr(6'h02, 8'h00);
		chk(wlev, 0);
		@(posedge clk) {init_done, rate} <= 4'hD;
		repeat (6) @(posedge clk);
		rd(6'h04, 8'h85);
		rd(6'h04, 8'h05);
		@(posedge clk) derate <= 1'b1;
		repeat (6) @(posedge clk);
		rd(6'h04, 8'h86);
		wr(6'h04, 8'hFF);
		rd(6'h04, 8'h7E);
		chk({toff, re, src}, 4'hF);
		wr(6'h04, 8'h00);
		chk(re, 0);
		wr(6'h03, 8'h35);
		wr(6'h04, 8'h10);
		chk({prot, re}, 2'b10);
		wr(6'h03, 8'h31);
		chk(prot, 1);
		@(posedge clk) rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(prot, 0);
		tally_and_finish();
	end
endmodule // test_lmr_mode_regs
bind lmr_mode_regs lmr_mode_regs_props #(
	.MAKER_ID(MAKER_ID)
) lmr_mode_regs_props_i (
	.ref_clk_i                  (ref_clk_i),
	.rst_b_i                    (rst_b_i),
	.mrr_i                      (mrr_i),
	.ma_i                       (ma_i),
	.rd_data_o                  (rd_data_o),
	.rd_valid_o                 (rd_valid_o),
	.read_latency_o             (read_latency_o),
	.write_latency_o            (write_latency_o),
	.rtp_count_o                (rtp_count_o),
	.repair_protection_o        (repair_protection_o),
	.repair_entry_o             (repair_entry_o),
	.precharge_o                (precharge_o),
	.pulldown_drive_strength_o  (pulldown_drive_strength_o),
	.pullup_calibration_point_o (pullup_calibration_point_o)
);
`default_nettype wire
